/* File: cgc_pkg.sv */
// constants, types and helpers shared by the clock generator core
package cgc_pkg;

  // ***************************************************************
  // register map, byte addresses on the apb
  // ***************************************************************
  localparam int          CGC_ADDR_W     = 8;
  localparam logic [7:0]  CGC_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  CGC_OFS_MULT   = 8'h04;
  localparam logic [7:0]  CGC_OFS_CONFIG = 8'h08;
  localparam logic [7:0]  CGC_OFS_STATUS = 8'h0c;

  // field positions
  localparam int CGC_CTRL_INT_ON  = 0;
  localparam int CGC_CTRL_EXT_ON  = 1;
  localparam int CGC_CTRL_SEL_EXT = 2;
  localparam int CGC_CFG_KEEP     = 0;
  localparam int CGC_CFG_EXT_OK   = 1;
  localparam int CGC_CFG_XTAL_OK  = 2;
  localparam int CGC_ST_WORD_LSB  = 16;

  // values after reset
  localparam logic       CGC_RST_INT_ON = 1'b1;
  localparam logic [7:0] CGC_RST_MULT   = 8'h01;

  // ***************************************************************
  // loop filter and ring oscillator
  // ***************************************************************
  localparam int          CGC_WORD_W     = 12;
  localparam logic [11:0] CGC_STEP_BIG   = 12'h020;
  localparam logic [11:0] CGC_STEP_MID   = 12'h008;
  localparam logic [11:0] CGC_STEP_FINE  = 12'h001;
  localparam logic [3:0]  CGC_COARSE_MAX = 4'h9;

  // six error bands from the frequency comparator
  typedef enum logic [2:0] {
    CGC_SLOW_BIG  = 3'b000,   // base < 0.85 nominal
    CGC_SLOW_MID  = 3'b001,   // 0.85 .. 0.95
    CGC_SLOW_FINE = 3'b010,   // 0.95 .. 1.00
    CGC_FAST_FINE = 3'b011,   // 1.00 .. 1.05
    CGC_FAST_MID  = 3'b100,   // 1.05 .. 1.15
    CGC_FAST_BIG  = 3'b101    // above 1.15
  } cgc_band_type;

  typedef struct packed {
    logic         valid;      // one comparison completed
    cgc_band_type band;       // its error band
  } cgc_cmp_type;

  typedef struct packed {
    logic [11:0] word;
    logic        stable;
  } cgc_filt_state_type;

  // coarse settings above nine act as nine, the slowest
  function automatic logic [3:0] cgc_eff_coarse(input logic [3:0] c);
    cgc_eff_coarse = (c > CGC_COARSE_MAX) ? CGC_COARSE_MAX : c;
  endfunction

endpackage

/* File: cgc_loop_filter.sv */
// digital loop filter: steps the oscillator control word per comparison
`timescale 1ns/1ns
module cgc_loop_filter (
  input  wire logic               pclk,     // system clock
  input  wire logic               presetn,  // async reset, low
  input  wire logic               enable,   // internal generator running
  input  wire cgc_pkg::cgc_cmp_type cmp,    // comparator result
  output logic [11:0]             word,     // coarse:stage word
  output logic                    stable    // error within 5 percent
);
  import cgc_pkg::*;

  cgc_filt_state_type s;
  cgc_filt_state_type next_s;

  // ***************************************************************
  // next state
  // ***************************************************************
  // the 12-bit add lets stage carries and borrows ripple into the
  // coarse field; overflow simply wraps and is walked back by steps
  always_comb begin
    next_s = s;
    if (enable && cmp.valid) begin
      case (cmp.band)
        CGC_SLOW_BIG:  next_s.word = s.word - CGC_STEP_BIG;   // see R14 R15 R16
        CGC_SLOW_MID:  next_s.word = s.word - CGC_STEP_MID;   // see R14 R15
        CGC_SLOW_FINE: next_s.word = s.word - CGC_STEP_FINE;  // see R14 R15
        CGC_FAST_FINE: next_s.word = s.word + CGC_STEP_FINE;  // see R14 R15
        CGC_FAST_MID:  next_s.word = s.word + CGC_STEP_MID;   // see R14 R15
        CGC_FAST_BIG:  next_s.word = s.word + CGC_STEP_BIG;   // see R14 R15 R18
        default:       next_s.word = s.word;                  // see R20
      endcase
      next_s.stable = (cmp.band == CGC_SLOW_FINE) ||
                      (cmp.band == CGC_FAST_FINE);            // see R19
    end
    if (!enable) begin
      next_s.stable = 1'b0;  // a stopped generator is not accurate
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign word   = s.word;
  assign stable = s.stable;

endmodule

/* File: cgc_core.sv */
// clock generator core: enables, divider, loop filter and apb registers
//
// Contract
// R1 - bus clock is osc_out_clk over four; gen_out_clk is osc_out_clk halved.
// R2 - stop mode with keep_osc_in_stop clear raises gen_stop, halting all clocks.
// R3 - with keep_osc_in_stop set, gen_stop stays low in stop mode.
// R4 - int_gen_en equals int_gen_on and not gen_stop.
// R5 - while int_gen_en is low, int_clk and base_clk are held low.
// R6 - ext_gen_en equals ext_gen_on and not gen_stop.
// R7 - setting ext_gen_on is ignored unless ext_clk_allow is set.
// R8 - while ext_gen_en is low, ext_clk is held low.
// R9 - osc1_port_en is low whenever ext_gen_on is set, even in stop.
// R10 - osc2_port_en is low when ext_gen_on and crystal_allow are set.
// R11 - int_clk runs at multiplier_reg times base_clk.
// R12 - base_clk is int_clk divided by the factor; zero or one passes through.
// R13 - int_clk period follows the twelve-bit coarse:stage word, 000 to 9ff.
// R14 - filter subtracts when slow, adds when fast, steps 32, 8 or 1.
// R15 - big step beyond 15 percent, medium 5 to 15, unit within 5.
// R16 - stage carry or borrow moves the coarse field.
// R17 - coarse values a to f behave like nine at the oscillator.
// R18 - overflow recovers by normal subtract steps; settling at a-f is fine.
// R19 - filter_stable is high while the error is within 5 percent.
// R20 - one correction step per completed comparison, six-band code.
`timescale 1ns/1ns
module cgc_core (
  input  wire logic                        pclk,            // apb and core clock
  input  wire logic                        presetn,         // async reset, low
  input  wire logic                        psel,            // apb select
  input  wire logic                        penable,         // apb access phase
  input  wire logic                        pwrite,          // apb direction
  input  wire logic [cgc_pkg::CGC_ADDR_W-1:0] paddr,        // apb byte address
  input  wire logic [31:0]                 pwdata,          // apb write data
  output logic [31:0]                      prdata,          // apb read data
  output logic                             pready,          // apb ready
  output logic                             pslverr,         // apb error
  input  wire logic                        stop_mode,       // mcu in stop
  input  wire logic                        osc_tick,        // ring oscillator half period
  input  wire logic                        osc1_in,         // external clock pin level
  input  wire cgc_pkg::cgc_cmp_type        cmp,             // comparator result
  output logic [3:0]                       dco_coarse,      // coarse setting to ring
  output logic [7:0]                       dco_stage,       // stage setting to ring
  output logic                             int_clk,         // internal clock
  output logic                             base_clk,        // divided base clock
  output logic                             ext_clk,         // external clock
  output logic                             osc_out_clk,     // selected oscillator clock
  output logic                             gen_out_clk,     // half of osc_out_clk
  output logic                             bus_clk,         // quarter of osc_out_clk
  output logic                             timebase_clk,    // timebase clock
  output logic                             gen_stop,        // generator stopped
  output logic                             int_gen_en,      // internal generator on
  output logic                             ext_gen_en,      // external generator on
  output logic                             osc1_port_en,    // port logic on osc1 pin
  output logic                             osc2_port_en,    // port logic on osc2 pin
  output logic                             filter_stable    // frequency within 5 percent
);
  import cgc_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic        int_gen_on;
    logic        ext_gen_on;
    logic        sel_ext;
    logic [7:0]  mult;
    logic        keep;
    logic        ext_allow;
    logic        xtal_allow;
    logic        gen_stop;
    logic        int_en;
    logic        ext_en;
    logic        osc1_en;
    logic        osc2_en;
    logic        int_clk;
    logic        base_clk;
    logic [7:0]  div_cnt;
    logic        ext_clk;
    logic        osc_out;
    logic        gen_out;
    logic        bus_clk;
    logic        tb_clk;
    logic [31:0] rdata;
    logic        err;
  } cgc_core_state_type;

  cgc_core_state_type s;
  cgc_core_state_type next_s;

  logic [11:0] word;
  logic        stable;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // decode shared by the read and the write path
  function automatic logic is_mapped(input logic [CGC_ADDR_W-1:0] a);
    is_mapped = (a == CGC_OFS_CTRL)   || (a == CGC_OFS_MULT) ||
                (a == CGC_OFS_CONFIG) || (a == CGC_OFS_STATUS);
  endfunction

  // read image of every register; unmapped reads as zero
  function automatic logic [31:0] read_word(
    input cgc_core_state_type      st,
    input logic [CGC_ADDR_W-1:0]   a,
    input logic [11:0]             w,
    input logic                    stb
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      CGC_OFS_CTRL: begin
        r[CGC_CTRL_INT_ON]  = st.int_gen_on;
        r[CGC_CTRL_EXT_ON]  = st.ext_gen_on;
        r[CGC_CTRL_SEL_EXT] = st.sel_ext;
      end
      CGC_OFS_MULT: begin
        r[7:0] = st.mult;
      end
      CGC_OFS_CONFIG: begin
        r[CGC_CFG_KEEP]    = st.keep;
        r[CGC_CFG_EXT_OK]  = st.ext_allow;
        r[CGC_CFG_XTAL_OK] = st.xtal_allow;
      end
      CGC_OFS_STATUS: begin
        r[0] = st.gen_stop;
        r[1] = st.int_en;
        r[2] = st.ext_en;
        r[3] = stb;
        r[4] = st.osc1_en;
        r[5] = st.osc2_en;
        r[CGC_ST_WORD_LSB +: CGC_WORD_W] = w;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    read_word = r;
  endfunction

  // ***************************************************************
  // loop filter
  // ***************************************************************
  // steps only while the generator runs, one per comparison
  cgc_loop_filter u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (s.int_en),   // see R20
    .cmp     (cmp),
    .word    (word),
    .stable  (stable)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic setup;
    logic wr;
    setup  = psel && !penable;
    wr     = psel && penable && pwrite;
    next_s = s;

    // stop and enable gating; port enables ignore gen_stop on purpose
    // so a pin lent to the oscillator is not handed back in stop
    next_s.gen_stop = stop_mode && !s.keep;                 // see R2 R3
    next_s.int_en   = s.int_gen_on && !next_s.gen_stop;     // see R4
    next_s.ext_en   = s.ext_gen_on && !next_s.gen_stop;     // see R6
    next_s.osc1_en  = !s.ext_gen_on;                        // see R9
    next_s.osc2_en  = !(s.ext_gen_on && s.xtal_allow);      // see R10

    // internal clock: one toggle per ring oscillator half period;
    // the divider counts int_clk rising edges up to the factor
    if (!next_s.int_en) begin
      next_s.int_clk  = 1'b0;                               // see R5
      next_s.base_clk = 1'b0;                               // see R5
      next_s.div_cnt  = 8'h00;
    end else if (osc_tick) begin
      next_s.int_clk = !s.int_clk;
      if (s.mult <= 8'h01) begin
        next_s.base_clk = !s.int_clk;                       // see R12
      end else if (!s.int_clk) begin
        if (s.div_cnt >= s.mult - 8'h01) begin
          next_s.div_cnt = 8'h00;                           // see R11 R12
        end else begin
          next_s.div_cnt = s.div_cnt + 8'h01;
        end
        next_s.base_clk = next_s.div_cnt < (s.mult >> 1);   // see R11
      end
    end

    // external path follows the pin only while enabled
    next_s.ext_clk = next_s.ext_en && osc1_in;              // see R8

    // selection and the divide chain toward the bus clock
    next_s.osc_out = s.sel_ext ? next_s.ext_clk : next_s.int_clk;
    if (next_s.osc_out && !s.osc_out) begin
      next_s.gen_out = !s.gen_out;                          // see R1
      if (!s.gen_out) begin
        next_s.bus_clk = !s.bus_clk;                        // see R1
      end
    end
    next_s.tb_clk = next_s.ext_en ? next_s.ext_clk : next_s.int_clk;

    // apb: read data and error are prepared in the setup phase so
    // the access phase can complete at once from flip-flops
    if (setup) begin
      next_s.rdata = read_word(s, paddr, word, stable);
      next_s.err   = !is_mapped(paddr);
    end
    if (wr) begin
      case (paddr)
        CGC_OFS_CTRL: begin
          next_s.int_gen_on = pwdata[CGC_CTRL_INT_ON];
          next_s.ext_gen_on = pwdata[CGC_CTRL_EXT_ON] && s.ext_allow;  // see R7
          next_s.sel_ext    = pwdata[CGC_CTRL_SEL_EXT];
        end
        CGC_OFS_MULT: begin
          next_s.mult = pwdata[7:0];                        // see R11
        end
        CGC_OFS_CONFIG: begin
          next_s.keep       = pwdata[CGC_CFG_KEEP];
          next_s.ext_allow  = pwdata[CGC_CFG_EXT_OK];
          next_s.xtal_allow = pwdata[CGC_CFG_XTAL_OK];
        end
        default: begin
          next_s.keep = s.keep;  // status is read only
        end
      endcase
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.int_gen_on <= CGC_RST_INT_ON;
      s.mult       <= CGC_RST_MULT;
      s.osc1_en    <= 1'b1;
      s.osc2_en    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // the ring sees the clamped coarse field; the filter keeps the raw
  // word so an overflow can still be walked back step by step
  assign dco_coarse = cgc_eff_coarse(word[11:8]);  // see R13 R17 R18
  assign dco_stage  = word[7:0];                   // see R13

  // bus answers in the access phase without wait states
  assign pready  = 1'b1;
  assign pslverr = psel && penable && s.err;
  assign prdata  = s.rdata;

  assign int_clk       = s.int_clk;
  assign base_clk      = s.base_clk;
  assign ext_clk       = s.ext_clk;
  assign osc_out_clk   = s.osc_out;
  assign gen_out_clk   = s.gen_out;
  assign bus_clk       = s.bus_clk;
  assign timebase_clk  = s.tb_clk;
  assign gen_stop      = s.gen_stop;
  assign int_gen_en    = s.int_en;
  assign ext_gen_en    = s.ext_en;
  assign osc1_port_en  = s.osc1_en;
  assign osc2_port_en  = s.osc2_en;
  assign filter_stable = stable;

endmodule

/* File: cgc_core_monitor.sv */
// checker: timing relations on the clock generator core ports
`timescale 1ns/1ns
module cgc_core_monitor (
  input wire logic                 pclk,          // clock
  input wire logic                 presetn,       // reset, low
  input wire cgc_pkg::cgc_cmp_type cmp,           // comparator
  input wire logic [3:0]           dco_coarse,    // coarse out
  input wire logic [7:0]           dco_stage,     // stage out
  input wire logic                 int_clk,       // internal clock
  input wire logic                 base_clk,      // base clock
  input wire logic                 ext_clk,       // external clock
  input wire logic                 gen_stop,      // stopped
  input wire logic                 int_gen_en,    // internal on
  input wire logic                 ext_gen_en,    // external on
  input wire logic                 osc1_port_en,  // pin 1 port
  input wire logic                 osc2_port_en,  // pin 2 port
  input wire logic                 filter_stable  // within 5 percent
);
  import cgc_pkg::*;
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ********
  // enables and gating; two cycles of stop so either update order passes
  // ********
  property p_stop;
    gen_stop && $past(gen_stop) |-> !int_gen_en && !ext_gen_en;
  endproperty
  a_stop: assert property (p_stop) else $error("enable up in stop");
  property p_int_off;
    !int_gen_en |-> !int_clk && !base_clk;
  endproperty
  a_int_off: assert property (p_int_off) else $error("int clock live");
  property p_ext_off;
    !ext_gen_en |-> !ext_clk;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("ext clock live");
  property p_ports;
    ext_gen_en || !osc2_port_en |-> !osc1_port_en;
  endproperty
  a_ports: assert property (p_ports) else $error("pin port enabled");
  // ********
  // loop filter steps, one per valid comparison
  // ********
  property p_up_big;
    cmp.valid && int_gen_en && cmp.band == CGC_FAST_BIG |=> dco_stage == $past(dco_stage) + 8'h20;
  endproperty
  a_up_big: assert property (p_up_big) else $error("big step wrong");
  property p_fine_dn;
    cmp.valid && int_gen_en && cmp.band == CGC_SLOW_FINE
      |=> filter_stable && dco_stage == $past(dco_stage) - 8'h01;
  endproperty
  a_fine_dn: assert property (p_fine_dn) else $error("fine step wrong");
  property p_hold;
    !cmp.valid |=> $stable(dco_stage) && $stable(dco_coarse);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved idle");
  // coarse nine is excluded: a field of ten also reads as nine
  property p_borrow;
    cmp.valid && int_gen_en && cmp.band == CGC_SLOW_BIG && dco_stage < 8'h20
      && dco_coarse inside {[4'h1:4'h8]} |=> dco_coarse == $past(dco_coarse) - 4'h1;
  endproperty
  a_borrow: assert property (p_borrow) else $error("no borrow");
endmodule
bind cgc_core cgc_core_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .cmp(cmp), .dco_coarse(dco_coarse),
  .dco_stage(dco_stage), .int_clk(int_clk), .base_clk(base_clk), .ext_clk(ext_clk),
  .gen_stop(gen_stop), .int_gen_en(int_gen_en), .ext_gen_en(ext_gen_en),
  .osc1_port_en(osc1_port_en), .osc2_port_en(osc2_port_en), .filter_stable(filter_stable)
);

/* File: cgc_far_model.sv */
// far-side model: ring ticks, external pin clock and comparator results
`timescale 1ns/1ns
module cgc_far_model (
  input  wire logic                  pclk,      // clock
  input  wire logic                  presetn,   // reset, low
  input  wire logic                  fire,      // request a result
  input  wire cgc_pkg::cgc_band_type band_in,   // band to report
  output logic                       osc_tick,  // ring half period
  output logic                       osc1_in,   // pin clock
  output cgc_pkg::cgc_cmp_type       cmp        // comparator result
);
  import cgc_pkg::*;
  logic [1:0] div3;
  // ticks every other cycle; the pin clock runs free at six cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_tick <= 1'b0;
      osc1_in  <= 1'b0;
      div3     <= 2'h0;
      cmp      <= '0;
    end else begin
      osc_tick <= ~osc_tick;
      div3     <= (div3 == 2'h2) ? 2'h0 : div3 + 2'h1;
      osc1_in  <= (div3 == 2'h2) ? ~osc1_in : osc1_in;
      // idle band shows noise so a design reading it unqualified slips
      cmp.valid <= fire;
      cmp.band  <= fire ? band_in : cgc_band_type'(~cmp.band);
    end
  end
endmodule

/* File: tb_top.sv */
// testbench: apb driven checks of the clock generator core
`timescale 1ns/1ns
module tb_top;
  import cgc_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, stop_mode, fire, e;
  logic         pready, pslverr, osc_tick, osc1_in, int_clk, base_clk, ext_clk;
  logic         osc_out_clk, gen_out_clk, bus_clk, gen_stop, int_gen_en, ext_gen_en;
  logic         osc1_port_en, osc2_port_en, filter_stable, timebase_clk;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, q;
  logic [3:0]   dco_coarse;
  logic [11:0]  w;
  logic [2:0]   b;
  logic [17:0]  mids = {3'd0, 3'd4, 3'd3, 3'd1, 3'd2, 3'd6};
  logic [7:0]   mults [4] = '{8'h0, 8'h1, 8'h3, 8'h5};
  logic [6:0]   now_v, prv;
  cgc_band_type band;
  cgc_cmp_type  cmp;
  int           err_count, check_count, cyc, k, n[7], s[7];

  always #50 pclk = ~pclk;
  cgc_core DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .osc_tick(osc_tick), .osc1_in(osc1_in), .cmp(cmp),
    .dco_coarse(dco_coarse), .dco_stage(), .int_clk(int_clk), .base_clk(base_clk),
    .ext_clk(ext_clk), .osc_out_clk(osc_out_clk), .gen_out_clk(gen_out_clk),
    .bus_clk(bus_clk), .timebase_clk(timebase_clk), .gen_stop(gen_stop), .int_gen_en(int_gen_en),
    .ext_gen_en(ext_gen_en), .osc1_port_en(osc1_port_en), .osc2_port_en(osc2_port_en),
    .filter_stable(filter_stable)
  );
  cgc_far_model u_far (
    .pclk(pclk), .presetn(presetn), .fire(fire), .band_in(band),
    .osc_tick(osc_tick), .osc1_in(osc1_in), .cmp(cmp)
  );

  // ********
  // free-running edge counters and the run ceiling
  // ********
  assign now_v = {timebase_clk, ext_clk, bus_clk, gen_out_clk, osc_out_clk, base_clk, int_clk};
  always @(posedge pclk) begin
    prv <= now_v;
    cyc <= cyc + 1;
    for (int i = 0; i < 7; i++) begin
      n[i] <= n[i] + int'(now_v[i] & ~prv[i]);
    end
    if (cyc == 10000) begin
      err_count++;
      print_verdict();
    end
  end

  // ********
  // bus tasks and comparisons
  // ********
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  // counts over a window differ by phase, so a tolerance is allowed
  task automatic near(input string nm, input int a, input int x, input int t);
    chk(nm, 32'(x), (a >= x - t && a <= x + t) ? 32'(x) : 32'(a));
  endtask
  // spacing of three idle edges lets the status flops settle first
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    repeat (2) @(posedge pclk);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask
  task automatic measure;
    @(negedge pclk);
    s = n;
    repeat (400) @(negedge pclk);
    foreach (s[i]) s[i] = n[i] - s[i];
  endtask
  function automatic logic [11:0] step(input logic [2:0] c);
    case (c)
      3'd0: step = 12'hfe0;
      3'd1: step = 12'hff8;
      3'd2: step = 12'hfff;
      3'd3: step = 12'h001;
      3'd4: step = 12'h008;
      3'd5: step = 12'h020;
      default: step = 12'h000;
    endcase
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    presetn = 1'b0;
    pclk = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    stop_mode = 1'b0;
    fire = 1'b0;
    band = CGC_SLOW_BIG;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl_rst", CGC_OFS_CTRL, 32'h1);
    rd("mult_rst", CGC_OFS_MULT, 32'(CGC_RST_MULT));
    rd("stat_rst", CGC_OFS_STATUS, 32'h32);
    apb(1'b1, CGC_OFS_STATUS, 32'hffffffff);
    rd("stat_ro", CGC_OFS_STATUS, 32'h32);
    rd("unmapped", 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, 32'(e));
    apb(1'b1, CGC_OFS_CTRL, 32'h3);
    rd("ext_refused", CGC_OFS_CTRL, 32'h1);
    apb(1'b1, CGC_OFS_CONFIG, 32'h2);
    apb(1'b1, CGC_OFS_CTRL, 32'h3);
    rd("ext_taken", CGC_OFS_CTRL, 32'h3);
    rd("stat_ext", CGC_OFS_STATUS, 32'h26);
    apb(1'b1, CGC_OFS_CONFIG, 32'h6);
    rd("stat_xtal", CGC_OFS_STATUS, 32'h6);
    stop_mode <= 1'b1;
    rd("stat_stop", CGC_OFS_STATUS, 32'h1);
    apb(1'b1, CGC_OFS_CONFIG, 32'h7);
    rd("stat_keep", CGC_OFS_STATUS, 32'h6);
    stop_mode <= 1'b0;
    apb(1'b1, CGC_OFS_CTRL, 32'h7);
    measure();
    near("ext_rate", s[5], 66, 2);
    near("tb_ext", s[6], 66, 2);
    near("gen_half", 2 * s[3], s[2], 2);
    near("bus_quarter", 4 * s[4], s[2], 4);
    apb(1'b1, CGC_OFS_CTRL, 32'h1);
    apb(1'b1, CGC_OFS_CONFIG, 32'h0);
    foreach (mults[i]) begin
      apb(1'b1, CGC_OFS_MULT, 32'(mults[i]));
      measure();
      k = (mults[i] < 8'h2) ? 1 : int'(mults[i]);
      near("base_div", k * s[1], s[0], k);
      near("tb_int", s[6], 100, 2);
    end
    w = 12'h0;
    for (int i = 0; i < 23; i++) begin
      b = (i < 8) ? 3'd5 : (i < 14) ? mids[17 - 3 * (i - 8) -: 3] : (i < 22) ? 3'd0 : 3'd3;
      @(posedge pclk);
      fire <= 1'b1;
      band <= cgc_band_type'(b);
      @(posedge pclk);
      fire <= 1'b0;
      apb(1'b0, CGC_OFS_STATUS, 32'h0);
      w = w + step(b);
      chk("word", 32'(w), 32'(q[27:16]));
      chk("stable", 32'(b inside {3'd2, 3'd3}), 32'(q[3]));
      chk("coarse", 32'((w[11:8] > 4'h9) ? 4'h9 : w[11:8]), 32'(dco_coarse));
    end
    stop_mode <= 1'b1;
    rd("stat_halt", CGC_OFS_STATUS, {4'h0, w, 16'h0031});
    print_verdict();
  end
endmodule
